// File: include/ctm_pkg.sv
// Purpose: Shared constants and types for the compact timer control block
// Assumes: Byte-wide register port, one clock domain
// Notes:   Offsets are register indices on the plain port

package ctm_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned CNT_W  = 10;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PER_SHIFT = 7;

  // ==========================================================================
  // Register offsets
  localparam logic [2:0] OFF_TIMER_CONTROL       = 3'h0;
  localparam logic [2:0] OFF_MODE_OUTPUT_CONTROL = 3'h1;
  localparam logic [2:0] OFF_COUNT_VALUE_LOW     = 3'h2;
  localparam logic [2:0] OFF_COUNT_VALUE_HIGH    = 3'h3;
  localparam logic [2:0] OFF_COMPARE_A_LOW       = 3'h4;
  localparam logic [2:0] OFF_COMPARE_A_HIGH      = 3'h5;

  // ==========================================================================
  // Field positions in timer control
  localparam int unsigned POS_PAUSE    = 7;
  localparam int unsigned POS_TIMER_ON = 3;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] RST_MODE_CTRL     = 8'h00;
  localparam logic [9:0] RST_COUNT         = 10'h000;
  localparam logic [9:0] RST_COMPARE_A     = 10'h000;
  localparam logic [7:0] RST_BUF           = 8'h00;

  // ==========================================================================
  // Encodings
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_PWM     = 2'h2;
  localparam logic [1:0] MODE_TIMER   = 2'h3;

  localparam logic [1:0] ACT_NONE     = 2'h0;
  localparam logic [1:0] ACT_LOW      = 2'h1;
  localparam logic [1:0] ACT_HIGH     = 2'h2;
  localparam logic [1:0] ACT_TOGGLE   = 2'h3;

  localparam logic [1:0] PWM_INACTIVE = 2'h0;
  localparam logic [1:0] PWM_ACTIVE   = 2'h1;
  localparam logic [1:0] PWM_WAVE     = 2'h2;

  // Full-range period: counter overflow after 1024 ticks
  localparam logic [10:0] FULL_PERIOD = 11'h400;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [1:0] op_mode_field;
    logic [1:0] pin_action_field;
    logic       initial_level_bit;
    logic       output_polarity_bit;
    logic       pwm_role_swap;
    logic       clear_select;
  } mode_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

endpackage : ctm_pkg

// File: design/ctm_counter.sv
// Purpose: 10-bit up-counter with clear targets and match strobes
// Assumes: tick is a one-cycle pulse on clk_sys
// Notes:   A target of zero never matches

`timescale 1ns/100ps
`default_nettype none

module ctm_counter #(
  parameter int unsigned W = 10
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  // Control
  input  wire logic         run,
  input  wire logic         start,
  input  wire logic         tick,
  input  wire logic [W:0]   clr_target,
  input  wire logic [W:0]   a_target,
  input  wire logic [W:0]   p_target,
  // Status
  output logic      [W-1:0] count,
  output logic              match_a,
  output logic              match_p
);
  import ctm_pkg::*;

  logic [W:0]   nxt_wide;
  logic         step;
  logic [W-1:0] count_ff;

  // ==========================================================================
  // Match detection
  assign step     = run & tick;
  assign nxt_wide = {1'b0, count_ff} + {{W{1'b0}}, 1'b1};
  assign match_a  = step & (a_target != '0) & (nxt_wide == a_target);
  assign match_p  = step & (p_target != '0) & (nxt_wide == p_target);
  assign count    = count_ff;

  // ==========================================================================
  // Counter
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count_ff <= RST_COUNT;
    end else if (start) begin
      count_ff <= '0;
    end else if (step) begin
      if (nxt_wide == clr_target) begin
        count_ff <= '0;
      end else begin
        count_ff <= nxt_wide[W-1:0];
      end
    end
  end

endmodule : ctm_counter

`default_nettype wire

// File: design/ctm_pin.sv
// Purpose: Timer output pin level for compare and PWM modes
// Assumes: Match strobes come from the counter on the same clock
// Notes:   Pin enable is low in timer/counter mode

`timescale 1ns/100ps
`default_nettype none

module ctm_pin #(
  parameter int unsigned W = 10
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // Control
  input  wire ctm_pkg::mode_ctrl_t ctrl,
  input  wire logic              start,
  input  wire logic              match_a,
  input  wire logic [W-1:0]      count,
  input  wire logic [W:0]        duty,
  // Pin
  output logic                   pin_o,
  output logic                   pin_b_o,
  output logic                   pin_oe
);
  import ctm_pkg::*;

  logic level_ff;
  logic pwm_raw;
  logic nxt_pin;
  logic pin_ff;
  logic oe_ff;

  // ==========================================================================
  // Compare mode level
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      level_ff <= 1'b0;
    end else if (start) begin
      level_ff <= ctrl.initial_level_bit;
    end else if (match_a && ctrl.op_mode_field == MODE_COMPARE) begin
      unique case (ctrl.pin_action_field)
        ACT_NONE:   level_ff <= level_ff;
        ACT_LOW:    level_ff <= 1'b0;
        ACT_HIGH:   level_ff <= 1'b1;
        ACT_TOGGLE: level_ff <= ~level_ff;
      endcase
    end
  end

  // ==========================================================================
  // Output selection
  always_comb begin
    unique case (ctrl.pin_action_field)
      PWM_ACTIVE: pwm_raw = 1'b1;
      PWM_WAVE:   pwm_raw = ({1'b0, count} < duty);
      default:    pwm_raw = 1'b0;
    endcase
    if (ctrl.op_mode_field == MODE_PWM) begin
      nxt_pin = ctrl.initial_level_bit ? pwm_raw : ~pwm_raw;
    end else begin
      nxt_pin = level_ff;
    end
    nxt_pin = nxt_pin ^ ctrl.output_polarity_bit;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_ff <= 1'b0;
      oe_ff  <= 1'b0;
    end else begin
      pin_ff <= nxt_pin;
      oe_ff  <= (ctrl.op_mode_field == MODE_COMPARE) |
                (ctrl.op_mode_field == MODE_PWM);
    end
  end

  assign pin_o   = pin_ff;
  assign pin_b_o = ~pin_ff;
  assign pin_oe  = oe_ff;

endmodule : ctm_pin

`default_nettype wire

// File: design/compact_timer.sv
// Operation
// - Period field times 128 ticks sets the P match; zero means 1024.
// - Period field zero lets the counter overflow instead of P matching.
// - Clear select 1 clears on A match; 0 on P match or overflow.
// - Clear select is ignored in PWM mode.
// - Mode 00 compare output, 10 PWM, 11 timer/counter, 01 undefined.
// - Pin level is undefined in timer/counter mode.
// - Compare mode A match: none, low, high or toggle the pin.
// - PWM mode action: inactive, active, waveform; 11 undefined.
// - Requested level equal to current level leaves the pin unchanged.
// - Timer-on rising edge returns the pin to its initial level.
// - Initial level bit: start level in compare, active level in PWM.
// - Polarity bit inverts the pin outside timer/counter mode.
// - Role swap exchanges period and duty sources in PWM mode.
// - Low count register shows counter bits 7 to 0, resets zero.
// - High count register shows bits 9 and 8, upper bits zero.
// - High byte read buffers low byte; low read returns buffer.
// - Timer-on rise clears the counter; fall holds its value.
// - The counter is a 10-bit up-counter on the selected tick.
//
// Purpose: Compact timer control, counter and output pin
// Assumes: tick_in is a one-cycle pulse from clock selection on clk_sys
// Notes:   Read data is registered and stands one cycle after the strobe

`timescale 1ns/100ps
`default_nettype none

module compact_timer #(
  parameter int unsigned CW = 10
) (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    arst_n,
  // Register port
  input  wire logic [ctm_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ctm_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [ctm_pkg::DATA_W-1:0] reg_rdata,
  // Timer tick
  input  wire logic                    tick_in,
  // Match events
  output logic                         match_a_evt,
  output logic                         match_p_evt,
  // Timer output pin
  output logic                         timer_output_pin,
  output logic                         timer_output_pin_b,
  output logic                         timer_output_pin_oe
);
  import ctm_pkg::*;

  // ==========================================================================
  // Declarations
  reg_req_t   req;
  logic [7:0] timer_ctrl_ff;
  mode_ctrl_t mode_ff;
  logic [9:0] cmp_a_ff;
  logic [7:0] cmp_a_buf_ff;
  logic [7:0] cnt_buf_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       on_prev_ff;
  logic       timer_on;
  logic       start;
  logic       run;
  logic [2:0] period_compare_field;
  logic [CW:0] period_compare_value;
  logic [CW:0] compare_value_a;
  logic [CW:0] a_period;
  logic [CW:0] clr_target;
  logic [CW:0] a_target;
  logic [CW:0] p_target;
  logic [CW:0] duty;
  logic [CW-1:0] count;
  logic       raw_a;
  logic       raw_p;
  logic       is_pwm;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ==========================================================================
  // Control decode
  assign timer_on  = timer_ctrl_ff[POS_TIMER_ON];
  assign run       = timer_on & ~timer_ctrl_ff[POS_PAUSE];
  assign start     = timer_on & ~on_prev_ff;
  assign is_pwm    = (mode_ff.op_mode_field == MODE_PWM);
  assign period_compare_field = timer_ctrl_ff[2:0];

  // P value in ticks: field times 128, zero means full range
  assign period_compare_value = (period_compare_field == 3'h0) ? FULL_PERIOD :
    {1'b0, period_compare_field, {PER_SHIFT{1'b0}}};

  assign compare_value_a = {1'b0, cmp_a_ff};
  assign a_period = (cmp_a_ff == '0) ? FULL_PERIOD : compare_value_a;

  // Clear target, match masks and duty per mode
  always_comb begin
    a_target = compare_value_a;
    p_target = period_compare_value;
    duty     = compare_value_a;
    if (is_pwm) begin
      if (mode_ff.pwm_role_swap) begin
        clr_target = a_period;
        duty       = period_compare_value;
      end else begin
        clr_target = period_compare_value;
      end
    end else if (mode_ff.clear_select) begin
      clr_target = a_period;
      p_target   = '0;
    end else begin
      clr_target = period_compare_value;
    end
  end

  // ==========================================================================
  // Counter
  ctm_counter #(
    .W          (CW)
  ) u_counter (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .run        (run),
    .start      (start),
    .tick       (tick_in),
    .clr_target (clr_target),
    .a_target   (a_target),
    .p_target   (p_target),
    .count      (count),
    .match_a    (raw_a),
    .match_p    (raw_p)
  );

  // Overflow at full range is no P match
  assign match_a_evt = raw_a;
  assign match_p_evt = raw_p & (period_compare_field != 3'h0);

  // ==========================================================================
  // Output pin
  ctm_pin #(
    .W       (CW)
  ) u_pin (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .ctrl    (mode_ff),
    .start   (start),
    .match_a (raw_a),
    .count   (count),
    .duty    (duty),
    .pin_o   (timer_output_pin),
    .pin_b_o (timer_output_pin_b),
    .pin_oe  (timer_output_pin_oe)
  );

  // ==========================================================================
  // Timer-on edge memory
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      on_prev_ff <= 1'b0;
    end else begin
      on_prev_ff <= timer_on;
    end
  end

  // ==========================================================================
  // Timer control register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      timer_ctrl_ff <= RST_TIMER_CONTROL;
    end else if (req.wr && req.addr == OFF_TIMER_CONTROL) begin
      timer_ctrl_ff <= req.wdata;
    end
  end

  // ==========================================================================
  // Mode and output control register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_ff <= RST_MODE_CTRL;
    end else if (req.wr && req.addr == OFF_MODE_OUTPUT_CONTROL) begin
      mode_ff <= req.wdata;
    end
  end

  // ==========================================================================
  // Compare value A pair, low byte through buffer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cmp_a_buf_ff <= RST_BUF;
      cmp_a_ff     <= RST_COMPARE_A;
    end else if (req.wr && req.addr == OFF_COMPARE_A_LOW) begin
      cmp_a_buf_ff <= req.wdata;
    end else if (req.wr && req.addr == OFF_COMPARE_A_HIGH) begin
      cmp_a_ff <= {req.wdata[1:0], cmp_a_buf_ff};
    end
  end

  // ==========================================================================
  // Count buffer, loaded by a high-byte read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_buf_ff <= RST_BUF;
    end else if (req.rd && req.addr == OFF_COUNT_VALUE_HIGH) begin
      cnt_buf_ff <= count[7:0];
    end
  end

  // ==========================================================================
  // Read path
  always_comb begin
    nxt_rdata = 8'h00;
    unique case (req.addr)
      OFF_TIMER_CONTROL:       nxt_rdata = timer_ctrl_ff;
      OFF_MODE_OUTPUT_CONTROL: nxt_rdata = mode_ff;
      OFF_COUNT_VALUE_LOW:     nxt_rdata = cnt_buf_ff;
      OFF_COUNT_VALUE_HIGH:    nxt_rdata = {6'h00, count[9:8]};
      OFF_COMPARE_A_LOW:       nxt_rdata = cmp_a_ff[7:0];
      OFF_COMPARE_A_HIGH:      nxt_rdata = {6'h00, cmp_a_ff[9:8]};
      default:                 nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
    end else if (req.rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule : compact_timer

`default_nettype wire

// File: bench/compact_timer_checker.sv
// Purpose: Port checker for compact_timer
// Assumes: Registers change only through the plain port
// Notes:   Shadows timer and mode control to judge events and pin

`timescale 1ns/100ps
`default_nettype none

module compact_timer_checker #(
  parameter int unsigned CW = 10
) (
  // Clock and reset
  input wire logic                         clk_sys,
  input wire logic                         arst_n,
  // Register port
  input wire logic [ctm_pkg::ADDR_W-1:0]   reg_addr,
  input wire logic [ctm_pkg::DATA_W-1:0]   reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [ctm_pkg::DATA_W-1:0]   reg_rdata,
  // Tick and events
  input wire logic                         tick_in,
  input wire logic                         match_a_evt,
  input wire logic                         match_p_evt,
  // Pin
  input wire logic                         timer_output_pin,
  input wire logic                         timer_output_pin_b,
  input wire logic                         timer_output_pin_oe
);
  import ctm_pkg::*;

  // ==========================================================================
  // Shadow registers
  logic [7:0] tc_ff;
  logic [7:0] mc_ff;
  logic [9:0] tk_ff;
  logic       arm_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tc_ff <= 8'h00;
      mc_ff <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == OFF_TIMER_CONTROL) tc_ff <= reg_wdata;
      if (reg_addr == OFF_MODE_OUTPUT_CONTROL) mc_ff <= reg_wdata;
    end
  end

  // ==========================================================================
  // Ticks since last P match
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tk_ff  <= 10'h000;
      arm_ff <= 1'b0;
    end else if (reg_wr && reg_addr <= OFF_MODE_OUTPUT_CONTROL) begin
      tk_ff  <= 10'h000;
      arm_ff <= 1'b0;
    end else if (match_p_evt) begin
      tk_ff  <= 10'h000;
      arm_ff <= 1'b1;
    end else if (tick_in && tc_ff[POS_TIMER_ON] && !tc_ff[POS_PAUSE]) begin
      tk_ff <= tk_ff + 10'h001;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_rd_high;
    reg_rd && reg_addr == OFF_COUNT_VALUE_HIGH;
  endsequence
  sequence s_rd_mode;
    reg_rd && reg_addr == OFF_MODE_OUTPUT_CONTROL;
  endsequence

  a_pin_inverse: assert property (timer_output_pin_b == !timer_output_pin)
    else $error("pin complement broken");
  a_oe_by_mode: assert property ($past(arst_n) && $stable(mc_ff[7:6])
                                 |-> timer_output_pin_oe == !mc_ff[6])
    else $error("pin enable wrong for mode");
  a_evt_on_tick: assert property ((match_a_evt || match_p_evt) |-> tick_in)
    else $error("match event without tick");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_high_upper: assert property (s_rd_high |=> reg_rdata[7:2] == 6'h00)
    else $error("count high upper bits set");
  a_mode_read: assert property (s_rd_mode |=> reg_rdata == $past(mc_ff))
    else $error("mode control readback wrong");
  a_no_p_zero: assert property (tc_ff[2:0] == 3'h0 |-> !match_p_evt)
    else $error("P match with zero period field");
  a_clr_a_no_p: assert property (mc_ff[7:6] != MODE_PWM && mc_ff[0] |-> !match_p_evt)
    else $error("P match while clearing on A");
  a_off_silent: assert property ((!tc_ff[POS_TIMER_ON] || tc_ff[POS_PAUSE])
                                  |-> !(match_a_evt || match_p_evt))
    else $error("match event while stopped");
  a_p_period: assert property (arm_ff && match_p_evt && mc_ff[1:0] == 2'b00
                               |-> tk_ff == {tc_ff[2:0], 7'h00} - 10'h001)
    else $error("P match period wrong");
endmodule : compact_timer_checker

bind compact_timer compact_timer_checker #(.CW(CW)) i_compact_timer_checker (
  .clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tick_in,
  .match_a_evt, .match_p_evt, .timer_output_pin, .timer_output_pin_b, .timer_output_pin_oe);

`default_nettype wire

// File: bench/tb_top.sv
// Purpose: Self-checking bench for compact_timer
// Assumes: Ticks and register cycles driven by the bench
// Notes:   Scenarios run in sequence, each judges its own results

`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import ctm_pkg::*;

  logic       clk_sys, arst_n, reg_wr, reg_rd, tick_in;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv, mc;
  logic       pin, pin_b, pin_oe, ma, mp, lvl;
  int         n_mismatch, check_count, na, np;

  compact_timer #(.CW(10)) i_compact_timer (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tick_in(tick_in),
    .match_a_evt(ma), .match_p_evt(mp), .timer_output_pin(pin),
    .timer_output_pin_b(pin_b), .timer_output_pin_oe(pin_oe));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    rv = reg_rdata;
  endtask : rd

  task automatic ticks(input int n);
    na = 0;
    np = 0;
    repeat (n) begin
      @(posedge clk_sys);
      tick_in <= 1'b1;
      @(negedge clk_sys);
      na += int'(ma === 1'b1);
      np += int'(mp === 1'b1);
      @(posedge clk_sys);
      tick_in <= 1'b0;
    end
    repeat (2) @(negedge clk_sys);
  endtask : ticks

  task automatic restart(input logic [7:0] m, input logic [7:0] t);
    wr(OFF_TIMER_CONTROL, t & 8'hF7);
    wr(OFF_MODE_OUTPUT_CONTROL, m);
    wr(OFF_TIMER_CONTROL, t | 8'h08);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : restart

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    rd(OFF_MODE_OUTPUT_CONTROL);
    chk(rv, 8'h00);
    rd(OFF_COUNT_VALUE_LOW);
    chk(rv, 8'h00);
    rd(OFF_COUNT_VALUE_HIGH);
    chk(rv, 8'h00);
    chk({pin_oe, pin}, 2'h2);
    wr(OFF_MODE_OUTPUT_CONTROL, 8'hA5);
    wr(3'h7, 8'hFF);
    rd(3'h6);
    chk(rv, 8'h00);
    rd(OFF_MODE_OUTPUT_CONTROL);
    chk(rv, 8'hA5);
    wr(OFF_COMPARE_A_LOW, 8'h03);
    wr(OFF_COMPARE_A_HIGH, 8'h00);
  endtask : t_reset

  task automatic t_counts;
    logic [7:0] m[4] = '{8'h00, 8'h01, 8'h00, 8'h81};
    logic [7:0] t[4] = '{8'h01, 8'h01, 8'h00, 8'h01};
    int         ea[4] = '{2, 85, 1, 2};
    int         ep[4] = '{2, 0, 0, 2};
    for (int i = 0; i < 4; i++) begin
      restart(m[i], t[i]);
      ticks(256);
      chk(16'(na), 16'(ea[i]));
      chk(16'(np), 16'(ep[i]));
    end
  endtask : t_counts

  task automatic t_buffer;
    restart(8'h00, 8'h00);
    ticks(300);
    rd(OFF_COUNT_VALUE_HIGH);
    chk(rv, 8'h01);
    ticks(1);
    rd(OFF_COUNT_VALUE_LOW);
    chk(rv, 8'h2C);
    ticks(723);
    chk(16'(np), 16'h0000);
    chk(16'(na), 16'h0000);
    rd(OFF_COUNT_VALUE_HIGH);
    chk(rv, 8'h00);
    rd(OFF_COUNT_VALUE_LOW);
    chk(rv, 8'h00);
  endtask : t_buffer

  task automatic t_compare;
    for (int k = 0; k < 16; k++) begin
      mc = {2'b00, k[1:0], k[3], k[2], 2'b00};
      restart(mc, 8'h01);
      chk(pin, k[3] ^ k[2]);
      ticks(3);
      lvl = k[1] ? (k[0] ? !k[3] : 1'b1) : (k[0] ? 1'b0 : k[3]);
      chk(pin, lvl ^ k[2]);
    end
  endtask : t_compare

  task automatic t_pwm;
    for (int k = 0; k < 4; k++) begin
      restart({2'b10, k[1:0], 4'h8}, 8'h01);
      chk(pin, k == 1 || k == 2);
      ticks(3);
      chk(pin, k == 1);
    end
    restart(8'hAA, 8'h01);
    ticks(3);
    chk(pin, 1'b1);
  endtask : t_pwm

  task automatic t_modes;
    restart(8'hC0, 8'h01);
    chk(pin_oe, 1'b0);
    ticks(3);
    chk(16'(na), 16'h0001);
    restart(8'hA4, 8'h01);
    chk(pin_oe, 1'b1);
    chk(pin, 1'b1);
  endtask : t_modes

  // ==========================================================================
  // Closing
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    arst_n    = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    tick_in   = 1'b0;
    reg_addr  = 3'h0;
    reg_wdata = 8'h00;
    n_mismatch  = 0;
    check_count = 0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(negedge clk_sys);
    t_reset();
    t_counts();
    t_buffer();
    t_compare();
    t_pwm();
    t_modes();
    end_sim();
  end
endmodule : tb_top

`default_nettype wire
